// *** ir_pkg.sv ***
// shared constants and types for the infrared capture and envelope block
package ir_pkg;
  // bus geometry
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  // register word index, byte address is four times it
  localparam logic [2:0]  REG_CTRL  = 3'h0;
  localparam logic [2:0]  REG_STAT  = 3'h1;
  localparam logic [2:0]  REG_CARR  = 3'h2;
  localparam logic [2:0]  REG_PER   = 3'h3;
  localparam logic [2:0]  REG_CNT   = 3'h4;
  // control register field positions
  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CTRL_TX   = 1;
  localparam int unsigned CTRL_EDGE = 2;
  localparam int unsigned CTRL_FINE = 4;
  localparam int unsigned CTRL_RLD  = 5;
  localparam int unsigned CTRL_BCM  = 6;
  localparam int unsigned CTRL_POL  = 7;
  localparam int unsigned CTRL_DATA = 8;
  localparam int unsigned CTRL_ENV  = 9;
  localparam int unsigned CTRL_DIV  = 11;
  localparam int unsigned CTRL_IE   = 14;
  localparam int unsigned CTRL_W    = 15;
  // status register field positions
  localparam int unsigned STAT_IRQ  = 0;
  localparam int unsigned STAT_OVF  = 1;
  // reset and special counter values
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
  localparam logic [15:0] CARR_RESET  = 16'h0000;
  localparam logic [15:0] CNT_ZERO    = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] BURST_START = 16'h0001;
  localparam logic [1:0]  SPACE_CYC   = 2'h2;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
  // receive edge choice
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;
  // envelope pin choice
  typedef enum logic [1:0] {
    ENV_OFF  = 2'b00,
    ENV_MOD  = 2'b01,
    ENV_FREE = 2'b10,
    ENV_RSVD = 2'b11
  } env_sel_t;
  // operating state
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RX_WAIT = 2'b01,
    ST_RX_RUN  = 2'b10,
    ST_TX_RUN  = 2'b11
  } ir_state_t;
endpackage

// *** ir_sync2.sv ***
// two flip-flop synchroniser for one pin level
module ir_sync2 (
  input  wire logic i_clock,
  input  wire logic i_rstn,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_r;  // first stage, read only by the second
  // two stages, frozen with the clock enable
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_ce) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// *** ir_carrier_gen.sv ***
// carrier generator: high and low phases counted in divided clocks
module ir_carrier_gen (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_ce,
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic [7:0] i_high,
  input  wire logic [7:0] i_low,
  output logic            o_level,
  output logic            o_cycle
);
  logic [7:0] cnt_r;  // ticks left in this phase
  logic       ph_r;   // current phase, high first
  wire        last = i_tick && (cnt_r == 8'h00);
  // one pulse as each full period ends
  assign o_cycle = i_run && last && !ph_r;
  assign o_level = ph_r;
  // phase counter, idles high and loaded
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_r  <= 1'b1;
      cnt_r <= 8'h00;
    end else if (i_ce) begin
      if (!i_run) begin
        ph_r  <= 1'b1;
        cnt_r <= i_high;
      end else if (last) begin
        ph_r  <= !ph_r;
        cnt_r <= ph_r ? i_low : i_high;
      end else if (i_tick) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
endmodule

// *** ir_receive_capture_envelope.sv ***
// infrared timer: receive capture, burst count and transmit envelope
// Summary of operation
// - envelope modes 01b/10b drive envelope pin
// - envelope pin shows sampled data_bit xor polarity in transmit, polarity otherwise
// - carrier pin modulated at 01b, free at 10b
// - receive when tx_mode low and enabled
// - edge_select picks qualified pin edges
// - counter starts at zero on first event
// - fine select picks divided clock or carrier
// - event stores pin level into data_bit
// - standard mode copies counter into period
// - capture_reload clears counter on events
// - counter wrap sets overflow and interrupt
// - receive runs until tx_mode or disable
// - standard mode flags interrupt per capture
// - burst mode disables the period capture
// - burst mode period counts qualified edges
// - two silent carrier cycles flag a space
// - entering burst mode loads period 0001h
// - burst mode keeps clock and reload choices
// - interrupt output gated by irq enable
// - carrier high/low last count plus one
// - transmit reloads counter after reaching zero
module ir_receive_capture_envelope
  import ir_pkg::*;
#(
  parameter int unsigned PRE_W = 8  // divided clock prescaler width
) (
  input  wire logic              i_clock,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [DATA_W-1:0] i_writedata,
  output logic      [DATA_W-1:0] o_readdata,
  output logic                   o_waitrequest,
  input  wire logic              i_receive_in_pin,
  output logic                   o_carrier_out_pin,
  output logic                   o_envelope_out_pin,
  output logic                   o_envelope_out_oe,
  output logic                   o_irq
);
  // the divider reaches 2 to the 7th
  if (PRE_W < 7) begin : g_chk
    $error("PRE_W must be at least 7");
  end

  // software registers
  logic [CTRL_W-1:0] ctrl_r;        // control fields
  logic              data_bit_r;    // transmit data or captured level
  logic              irq_flag_r;    // timer interrupt flag
  logic              ovf_flag_r;    // overflow flag
  logic [15:0]       carrier_r;     // carrier high and low counts
  logic [15:0]       period_r;      // interval period register
  logic [15:0]       counter_r;     // interval counter
  // bus slave state
  logic              wait_r;        // waitrequest, high until answered
  logic [DATA_W-1:0] rdata_r;       // read answer
  // internal state
  ir_state_t         state_r;       // operating state
  ir_state_t         state_nxt;
  logic [PRE_W-1:0]  pre_r;         // prescaler for divided clock
  logic              rx_d_r;        // last synchronised pin level
  logic              bcm_d_r;       // last burst mode bit
  logic [1:0]        space_r;       // carrier cycles since last edge
  logic              env_data_r;    // data sampled at boundary
  logic              env_pol_r;     // polarity sampled at boundary
  logic              carr_pin_r;    // carrier pin register
  logic              env_pin_r;     // envelope pin register
  logic              env_oe_r;      // envelope pin enable register
  logic              irq_r;         // interrupt output register
  logic [15:0]       counter_nxt;
  logic [15:0]       period_nxt;
  logic              carr_nxt;

  // control field decode
  wire       ir_enable     = ctrl_r[CTRL_EN];
  wire       tx_mode       = ctrl_r[CTRL_TX];
  wire       fine_sel      = ctrl_r[CTRL_FINE];
  wire       cap_reload    = ctrl_r[CTRL_RLD];
  wire       bcm           = ctrl_r[CTRL_BCM];
  wire       tx_polarity   = ctrl_r[CTRL_POL];
  wire       irq_en        = ctrl_r[CTRL_IE];
  wire [2:0] div_sel       = ctrl_r[CTRL_DIV +: 3];
  wire       edge_sel_t edge_select = edge_sel_t'(ctrl_r[CTRL_EDGE +: 2]);
  wire       env_sel_t env_select   = env_sel_t'(ctrl_r[CTRL_ENV +: 2]);
  wire [7:0] carrier_high  = carrier_r[15:8];
  wire [7:0] carrier_low   = carrier_r[7:0];

  // bus decode
  wire       req      = i_read || i_write;
  wire       accept   = req && !wait_r;
  wire       wr_acc   = i_write && !wait_r;
  wire [2:0] widx     = i_address[ADDR_W-1:2];
  wire       wr_ctrl  = wr_acc && (widx == REG_CTRL);
  wire       wr_stat  = wr_acc && (widx == REG_STAT);
  wire       wr_carr  = wr_acc && (widx == REG_CARR);
  wire       wr_per   = wr_acc && (widx == REG_PER);

  // read mux, unmapped words read zero
  wire [DATA_W-1:0] ctrl_view = DATA_W'({ctrl_r[CTRL_W-1:CTRL_DATA+1], data_bit_r,
                                         ctrl_r[CTRL_DATA-1:0]});
  wire [DATA_W-1:0] stat_view = DATA_W'({ovf_flag_r, irq_flag_r});
  wire [DATA_W-1:0] rd_mux =
    (widx == REG_CTRL) ? ctrl_view :
    (widx == REG_STAT) ? stat_view :
    (widx == REG_CARR) ? DATA_W'(carrier_r) :
    (widx == REG_PER)  ? DATA_W'(period_r) :
    (widx == REG_CNT)  ? DATA_W'(counter_r) : RD_ZERO;

  // receive pin crossing
  logic rx_s;
  ir_sync2 u_sync (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_async (i_receive_in_pin),
    .o_sync  (rx_s)
  );

  // edge detect after synchronisation
  wire rise  = rx_s && !rx_d_r;
  wire fall  = !rx_s && rx_d_r;
  wire qual  = ((edge_select == EDGE_RISE) && rise) ||
               ((edge_select == EDGE_FALL) && fall) ||
               ((edge_select == EDGE_BOTH) && (rise || fall));

  // divided clock tick every 2^div_sel cycles
  wire [PRE_W-1:0] pre_mask = ~({PRE_W{1'b1}} << div_sel);
  wire             ir_tick  = ((pre_r & pre_mask) == pre_mask);

  // carrier generator
  logic carr_lvl;
  logic car_cycle;
  ir_carrier_gen u_carr (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_ce    (i_ce),
    .i_run   (ir_enable),
    .i_tick  (ir_tick),
    .i_high  (carrier_high),
    .i_low   (carrier_low),
    .o_level (carr_lvl),
    .o_cycle (car_cycle)
  );

  // counter clock choice, kept in burst mode too
  wire cnt_tick = fine_sel ? ir_tick : car_cycle;

  // mode and event decode
  wire rx_act    = ir_enable && !tx_mode;
  wire tx_act    = ir_enable && tx_mode;
  wire tx_start  = tx_act && (state_r != ST_TX_RUN);
  wire tx_bound  = (state_r == ST_TX_RUN) && cnt_tick && (counter_r == CNT_ZERO);
  wire rx_cap    = (state_r == ST_RX_RUN) && qual;
  wire ovf_evt   = (state_r == ST_RX_RUN) && cnt_tick && (counter_r == CNT_MAX) &&
                   !qual;
  wire space_evt = (state_r == ST_RX_RUN) && bcm && car_cycle && !qual &&
                   (space_r == SPACE_CYC - 2'h1);
  wire bcm_rise  = bcm && !bcm_d_r;
  wire irq_set   = (rx_cap && !bcm) || space_evt || tx_bound;
  wire env_on    = (env_select == ENV_MOD) || (env_select == ENV_FREE);

  // state transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:    if (tx_act) state_nxt = ST_TX_RUN;
                  else if (rx_act) state_nxt = ST_RX_WAIT;
      ST_RX_WAIT: if (!rx_act) state_nxt = tx_act ? ST_TX_RUN : ST_IDLE;
                  else if (qual) state_nxt = ST_RX_RUN;
      ST_RX_RUN:  if (!rx_act) state_nxt = tx_act ? ST_TX_RUN : ST_IDLE;
      ST_TX_RUN:  if (!ir_enable) state_nxt = ST_IDLE;
                  else if (!tx_mode) state_nxt = ST_RX_WAIT;
    endcase
  end

  // interval counter next value
  always_comb begin
    counter_nxt = counter_r;
    if (tx_start) begin
      counter_nxt = period_r;
    end else begin
      unique case (state_r)
        ST_IDLE:    counter_nxt = counter_r;
        ST_RX_WAIT: counter_nxt = CNT_ZERO;
        ST_RX_RUN:  if (qual && cap_reload) counter_nxt = CNT_ZERO;
                    else if (cnt_tick) counter_nxt = counter_r + 16'h0001;
        ST_TX_RUN:  if (tx_bound) counter_nxt = period_r;
                    else if (cnt_tick) counter_nxt = counter_r - 16'h0001;
      endcase
    end
  end

  // period register next value, burst entry first
  always_comb begin
    period_nxt = period_r;
    if (bcm_rise) begin
      period_nxt = BURST_START;
    end else if (rx_cap && bcm) begin
      period_nxt = period_r + 16'h0001;
    end else if (rx_cap) begin
      period_nxt = counter_r;
    end else if (wr_per) begin
      period_nxt = i_writedata[15:0];
    end
  end

  // carrier pin choice
  always_comb begin
    if (!ir_enable) begin
      carr_nxt = 1'b0;
    end else if (state_r != ST_TX_RUN) begin
      carr_nxt = tx_polarity;
    end else if (env_select == ENV_FREE) begin
      carr_nxt = carr_lvl ^ env_pol_r;
    end else begin
      carr_nxt = env_data_r ? (carr_lvl ^ env_pol_r) : env_pol_r;
    end
  end

  // bus slave: one wait state, then answer
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_r  <= 1'b1;
      rdata_r <= RD_ZERO;
    end else if (i_ce) begin
      wait_r <= !(req && wait_r);
      if (i_read && wait_r) rdata_r <= rd_mux;
    end
  end

  // control and carrier registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r    <= CTRL_RESET;
      carrier_r <= CARR_RESET;
    end else if (i_ce) begin
      if (wr_ctrl) ctrl_r <= i_writedata[CTRL_W-1:0];
      if (wr_carr) carrier_r <= i_writedata[15:0];
    end
  end

  // data bit: capture beats software
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      data_bit_r <= 1'b0;
    end else if (i_ce) begin
      if (rx_cap) data_bit_r <= rx_s;
      else if (wr_ctrl) data_bit_r <= i_writedata[CTRL_DATA];
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_flag_r <= 1'b0;
      ovf_flag_r <= 1'b0;
    end else if (i_ce) begin
      irq_flag_r <= irq_set || (irq_flag_r && !(wr_stat && i_writedata[STAT_IRQ]));
      ovf_flag_r <= ovf_evt || (ovf_flag_r && !(wr_stat && i_writedata[STAT_OVF]));
    end
  end

  // timing state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r   <= ST_IDLE;
      counter_r <= CNT_ZERO;
      period_r  <= CNT_ZERO;
      pre_r     <= '0;
      rx_d_r    <= 1'b0;
      bcm_d_r   <= 1'b0;
    end else if (i_ce) begin
      state_r   <= state_nxt;
      counter_r <= counter_nxt;
      period_r  <= period_nxt;
      pre_r     <= pre_r + 1'b1;
      rx_d_r    <= rx_s;
      bcm_d_r   <= bcm;
    end
  end

  // silent carrier cycle count for space detection
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      space_r <= 2'h0;
    end else if (i_ce) begin
      if (qual || (state_r != ST_RX_RUN) || !bcm) space_r <= 2'h0;
      else if (car_cycle && (space_r != SPACE_CYC)) space_r <= space_r + 2'h1;
    end
  end

  // transmit samples at start and each boundary
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      env_data_r <= 1'b0;
      env_pol_r  <= 1'b0;
    end else if (i_ce) begin
      if (tx_start || tx_bound) begin
        env_data_r <= data_bit_r;
        env_pol_r  <= tx_polarity;
      end
    end
  end

  // registered pins and interrupt
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      carr_pin_r <= 1'b0;
      env_pin_r  <= 1'b0;
      env_oe_r   <= 1'b0;
      irq_r      <= 1'b0;
    end else if (i_ce) begin
      carr_pin_r <= carr_nxt;
      env_oe_r   <= ir_enable && env_on;
      env_pin_r  <= (state_r == ST_TX_RUN) ? (env_data_r ^ env_pol_r) : tx_polarity;
      irq_r      <= irq_en && (irq_flag_r || ovf_flag_r);
    end
  end

  assign o_readdata         = rdata_r;
  assign o_waitrequest      = wait_r;
  assign o_carrier_out_pin  = carr_pin_r;
  assign o_envelope_out_pin = env_pin_r;
  assign o_envelope_out_oe  = env_oe_r;
  assign o_irq              = irq_r;

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_env_boundary: assert property (
    i_ce && tx_bound ##1 i_ce |=> env_pin_r == $past(data_bit_r ^ tx_polarity, 2))
    else $error("envelope pin does not follow sampled data");
  a_rx_start_zero: assert property (
    i_ce && (state_r == ST_RX_WAIT) && rx_act && qual |=> counter_r == CNT_ZERO)
    else $error("counter did not start from zero");
  a_data_capture: assert property (
    i_ce && rx_cap |=> data_bit_r == $past(rx_s))
    else $error("captured level not stored");
  a_period_copy: assert property (
    i_ce && rx_cap && !bcm && !bcm_rise |=> period_r == $past(counter_r))
    else $error("period not captured from counter");
  a_reload_clear: assert property (
    i_ce && rx_cap && cap_reload && !tx_start |=> counter_r == CNT_ZERO)
    else $error("counter not cleared on event");
  a_overflow_set: assert property (
    i_ce && ovf_evt |=> ovf_flag_r ##1 (!i_ce || !irq_en || o_irq))
    else $error("overflow flag or interrupt missing");
  a_burst_entry: assert property (
    i_ce && bcm_rise |=> period_r == BURST_START)
    else $error("burst entry did not load one");
  a_irq_gate: assert property (
    i_ce && !irq_en |=> !o_irq)
    else $error("interrupt raised while disabled");
  a_tx_reload: assert property (
    i_ce && tx_bound && tx_act |=> counter_r == $past(period_r))
    else $error("transmit counter not reloaded");
  a_env_enable: assert property (
    i_ce && ir_enable && env_on |=> o_envelope_out_oe)
    else $error("envelope pin not enabled");
endmodule

// *** ir_remote_model.sv ***
// far-side receiver model: drives edges onto the receive pin
module ir_remote_model (
  input  wire logic       i_clock,
  input  wire logic       i_rstn,
  input  wire logic       i_go,
  input  wire logic [7:0] i_half,
  input  wire logic [7:0] i_edges,
  output logic            o_level,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gap_r;   // cycles left before next edge
  logic [7:0] left_r;  // edges still to send
  // busy while edges remain
  assign o_busy = (left_r != 8'h00);
  // demodulator output idles high; edges every i_half+1 cycles
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_level <= 1'b1;
      gap_r   <= 8'h00;
      left_r  <= 8'h00;
    end else if (i_go) begin
      gap_r  <= i_half;
      left_r <= i_edges;
    end else if (o_busy) begin
      if (gap_r == 8'h00) begin
        o_level <= ~o_level;
        left_r  <= left_r - 8'h01;
        gap_r   <= i_half;
      end else begin
        gap_r <= gap_r - 8'h01;
      end
    end
  end
endmodule

// *** test_ir_receive_capture_envelope.sv ***
// self-checking bench for the infrared capture and envelope block
module test_ir_receive_capture_envelope
  import ir_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rexp;
  } row_t;
  logic              i_clock;      // system clock
  logic              i_rstn;       // async reset, low active
  logic              i_read;       // bus read
  logic              i_write;      // bus write
  logic [ADDR_W-1:0] i_address;    // bus byte address
  logic [DATA_W-1:0] i_writedata;  // bus write data
  logic [DATA_W-1:0] o_readdata;   // bus read data
  logic              o_waitrequest;
  logic              rx_pin;       // receive pin from the model
  logic              o_carrier_out_pin;
  logic              o_envelope_out_pin;
  logic              o_envelope_out_oe;
  logic              o_irq;
  logic              go;           // model start strobe
  logic              ce;           // clock enable of the block
  logic [7:0]        half;         // model edge spacing
  logic [7:0]        edges;        // model edge count
  logic              busy;         // model still sending
  logic [DATA_W-1:0] q;            // last read value
  int                len;          // measured run length
  int                mismatches;
  int                compares;
  // ordinary register accesses
  row_t rows [6] = '{
    '{5'h08, 32'hABCD_1203, 32'h0000_1203},  // upper bits read zero
    '{5'h0C, 32'h0000_BEEF, 32'h0000_BEEF},  // period read/write
    '{5'h10, 32'h0000_5555, 32'h0000_0000},  // counter is read only
    '{5'h14, 32'hFFFF_FFFF, 32'h0000_0000},  // unmapped word
    '{5'h00, 32'h0000_4000, 32'h0000_4000},  // irq enable alone
    '{5'h04, 32'h0000_0003, 32'h0000_0000}   // nothing to clear
  };
  ir_receive_capture_envelope dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(ce), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .i_receive_in_pin(rx_pin), .o_carrier_out_pin(o_carrier_out_pin),
    .o_envelope_out_pin(o_envelope_out_pin), .o_envelope_out_oe(o_envelope_out_oe),
    .o_irq(o_irq)
  );
  ir_remote_model far (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_go(go), .i_half(half),
    .i_edges(edges), .o_level(rx_pin), .o_busy(busy)
  );
  // 40 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // compare and count
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then stop
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // one Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clock);
    i_write     <= wr;
    i_read      <= !wr;
    i_address   <= a;
    i_writedata <= d;
    do begin
      @(posedge i_clock);
    end while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_write <= 1'b0;
    i_read  <= 1'b0;
  endtask
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus(1'b0, a, RD_ZERO);
    check(q, e);
  endtask
  // control word builder, divider fixed at zero
  function automatic logic [DATA_W-1:0] ctl(input logic en, tx, input logic [1:0] eg,
      input logic fn, rl, bc, po, db, input logic [1:0] ev, input logic ie);
    ctl = RD_ZERO;
    ctl[CTRL_EN] = en;
    ctl[CTRL_TX] = tx;
    ctl[CTRL_EDGE+:2] = eg;
    ctl[CTRL_FINE] = fn;
    ctl[CTRL_RLD] = rl;
    ctl[CTRL_BCM] = bc;
    ctl[CTRL_POL] = po;
    ctl[CTRL_DATA] = db;
    ctl[CTRL_ENV+:2] = ev;
    ctl[CTRL_IE] = ie;
  endfunction
  // let the model send n edges spaced h+1 cycles, then settle
  task automatic pins(input logic [7:0] h, input logic [7:0] n);
    @(posedge i_clock);
    go    <= 1'b1;
    half  <= h;
    edges <= n;
    @(posedge i_clock);
    go <= 1'b0;
    @(posedge i_clock);
    for (int k = 0; k < 3000 && busy; k++) @(posedge i_clock);
    wt(8);
  endtask
  // length of one high phase of the carrier pin
  task automatic hirun();
    len = 0;
    for (int k = 0; k < 60 && o_carrier_out_pin !== 1'b0; k++) @(posedge i_clock);
    for (int k = 0; k < 60 && o_carrier_out_pin !== 1'b1; k++) @(posedge i_clock);
    for (int k = 0; k < 60 && o_carrier_out_pin === 1'b1; k++) begin
      @(posedge i_clock);
      len++;
    end
  endtask
  // watchdog well beyond the expected ~70k cycles
  initial begin
    #(25ns * 90000);
    mismatches++;
    conclude();
  end
  // main sequence
  initial begin
    mismatches = 0;
    compares = 0;
    i_rstn = 1'b0;
    {i_read, i_write, go} = 3'h0;
    ce = 1'b1;
    i_address = 5'h00;
    i_writedata = RD_ZERO;
    half = 8'h00;
    edges = 8'h00;
    wt(4);
    i_rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].rexp);
    end
    $display("test register table done");
    // reset with the block idle; the register table leaves carrier, period and irq enable written
    @(posedge i_clock);
    i_rstn <= 1'b0;
    wt(2);
    check({28'h0, o_waitrequest, o_irq, o_envelope_out_oe, o_carrier_out_pin}, 32'h8);
    i_rstn <= 1'b1;
    rdchk(5'h00, {17'h0, CTRL_RESET});
    rdchk(5'h08, {16'h0, CARR_RESET});
    rdchk(5'h10, {16'h0, CNT_ZERO});
    $display("test reset done");
    // standard capture on both edges, fine clock, reload
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_BOTH, 1, 1, 0, 0, 0, ENV_OFF, 1));
    pins(8'h27, 8'h02);
    bus(1'b0, 5'h0C, RD_ZERO);
    check({31'h0, q >= 32'h27 && q <= 32'h29}, 32'h1);
    rdchk(5'h00, ctl(1, 0, EDGE_BOTH, 1, 1, 0, 0, 1, ENV_OFF, 1));
    rdchk(5'h04, 32'h1);
    check({31'h0, o_irq}, 32'h1);
    bus(1'b1, 5'h04, 32'h3);
    wt(3);
    check({31'h0, o_irq}, 32'h0);
    // carrier-cycle counting: two clocks per cycle, irq masked
    bus(1'b1, 5'h08, 32'h0);
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_BOTH, 0, 1, 0, 0, 1, ENV_OFF, 0));
    pins(8'h27, 8'h02);
    bus(1'b0, 5'h0C, RD_ZERO);
    check({31'h0, q >= 32'h13 && q <= 32'h15}, 32'h1);
    rdchk(5'h04, 32'h1);
    check({31'h0, o_irq}, 32'h0);
    pins(8'h05, 8'h01);
    bus(1'b0, 5'h00, RD_ZERO);
    check({31'h0, q[CTRL_DATA]}, 32'h0);
    $display("test capture done");
    // unqualified edges and disabled block capture nothing
    bus(1'b1, 5'h04, 32'h3);
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_FALL, 1, 1, 0, 0, 0, ENV_OFF, 1));
    pins(8'h05, 8'h01);
    rdchk(5'h04, 32'h0);
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_NONE, 1, 1, 0, 0, 0, ENV_OFF, 1));
    pins(8'h05, 8'h01);
    rdchk(5'h04, 32'h0);
    bus(1'b1, 5'h00, ctl(0, 0, EDGE_BOTH, 1, 1, 0, 0, 0, ENV_OFF, 1));
    pins(8'h05, 8'h01);
    rdchk(5'h04, 32'h0);
    $display("test refusals done");
    // burst count: entry loads one, rises counted, space flagged once
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_RISE, 0, 1, 1, 0, 0, ENV_OFF, 1));
    rdchk(5'h0C, {16'h0, BURST_START});
    wt(10);
    bus(1'b1, 5'h04, 32'h3);
    rdchk(5'h04, 32'h0);
    pins(8'h01, 8'h06);
    rdchk(5'h0C, 32'h3);
    wt(12);
    rdchk(5'h04, 32'h1);
    $display("test burst done");
    // transmit envelope and carrier pins
    bus(1'b1, 5'h08, 32'h0200);
    bus(1'b1, 5'h0C, 32'h3);
    bus(1'b1, 5'h00, ctl(1, 1, EDGE_NONE, 1, 0, 0, 0, 1, ENV_FREE, 0));
    wt(40);
    check({30'h0, o_envelope_out_oe, o_envelope_out_pin}, 32'h3);
    hirun();
    check(32'(len), 32'h3);
    // divider of two doubles every carrier phase
    bus(1'b1, 5'h00, ctl(1, 1, EDGE_NONE, 1, 0, 0, 0, 1, ENV_FREE, 0) | (32'h1 << CTRL_DIV));
    wt(4);
    hirun();
    check(32'(len), 32'h6);
    bus(1'b1, 5'h00, ctl(1, 1, EDGE_NONE, 1, 0, 0, 1, 1, ENV_MOD, 0));
    wt(40);
    check({30'h0, o_envelope_out_oe, o_envelope_out_pin}, 32'h2);
    bus(1'b1, 5'h00, ctl(1, 1, EDGE_NONE, 1, 0, 0, 0, 0, ENV_MOD, 0));
    wt(40);
    len = 0;
    for (int k = 0; k < 20; k++) begin
      @(posedge i_clock);
      len += int'(o_carrier_out_pin !== 1'b0);
    end
    check({31'h0, o_envelope_out_pin}, 32'h0);
    check(32'(len), 32'h0);
    bus(1'b1, 5'h00, ctl(1, 1, EDGE_NONE, 1, 0, 0, 0, 1, ENV_OFF, 0));
    wt(4);
    check({31'h0, o_envelope_out_oe}, 32'h0);
    $display("test transmit done");
    // free-running counter wraps before any second event
    bus(1'b1, 5'h00, ctl(1, 0, EDGE_BOTH, 1, 0, 0, 0, 0, ENV_OFF, 1));
    bus(1'b1, 5'h04, 32'h3);
    pins(8'h05, 8'h01);
    wt(65600);
    bus(1'b0, 5'h04, RD_ZERO);
    check({31'h0, q[STAT_OVF]}, 32'h1);
    check({31'h0, o_irq}, 32'h1);
    // clock enable low freezes the free-running counter
    bus(1'b0, 5'h10, RD_ZERO);
    len = int'(q[15:0]);
    @(posedge i_clock);
    ce <= 1'b0;
    wt(20);
    ce <= 1'b1;
    bus(1'b0, 5'h10, RD_ZERO);
    check(32'(q[15:0] - 16'(len)), 32'h4);
    $display("test overflow done");
    conclude();
  end
endmodule
